//--- hdl/jtag_boundary_scan_tap.sv
// Boundary-scan test access port with instruction decode, data registers and pin control.
`timescale 1ns/1ps
module jtag_boundary_scan_tap
    import tap_pkg::*;
#(
    parameter logic [DR_LEN-1:0] IDCODE_VAL = IDCODE_DEFAULT, // Arbitrary value.
    parameter logic [DR_LEN-1:0] USERCODE_VAL = USERCODE_DEFAULT
) (
    // System clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Test port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Supplies
    input wire logic core_supply,
    input wire logic io_bank_supply,
    output logic normal_op,
    // Core logic
    input wire logic [NPINS-1:0] core_out,
    input wire logic [NPINS-1:0] core_oe,
    // Device pins
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    output logic pin_keeper_en,
    // User chains
    input wire logic user_chain_a_tdo,
    input wire logic user_chain_b_tdo,
    output logic user_chain_a_sel,
    output logic user_chain_b_sel,
    output logic user_capture,
    output logic user_shift,
    output logic user_update
);

    // ****************************************************************
    // Test clock domain
    // ****************************************************************
    logic core_ok;
    logic tap_reset;
    tap_state_e state;
    tap_state_e next_state;
    logic [NPINS-1:0] pin_sync;
    logic [IR_LEN-1:0] ir_shift, next_ir_shift;
    logic [IR_LEN-1:0] instr, next_instr;
    logic bypass, next_bypass;
    logic [DR_LEN-1:0] word, next_word;
    logic [BSR_LEN-1:0] bsr, next_bsr;
    logic [BSR_LEN-1:0] bsr_upd, next_bsr_upd;
    logic [1:0] mode, next_mode;
    logic upd_tgl, next_upd_tgl;
    logic next_a_sel, next_b_sel, next_ucap, next_ushift, next_uupd;
    logic next_tdo, next_tdo_oe;
    logic [2:0] sel;
    logic [1:0] instr_mode;

    // The port comes alive on the core supply alone; the banks are not waited for.
    level_sync u_core_sync (
        .clk(tck),
        .reset(1'b0),
        .d(core_supply),
        .q(core_ok)
    );
    assign tap_reset = ~core_ok;

    tap_fsm u_fsm (
        .tck(tck),
        .reset(tap_reset),
        .tms(tms),
        .state(state),
        .next_state(next_state)
    );

    for (genvar i = 0; i < NPINS; i++) begin : g_pin_sync
        level_sync u_pin_sync (
            .clk(tck),
            .reset(tap_reset),
            .d(pin_in[i]),
            .q(pin_sync[i])
        );
    end

    // Unlisted codes, including the programming set, fall back to bypass so the chain stays intact.
    always_comb begin
        sel = SEL_BYPASS;
        instr_mode = MODE_NORMAL;
        case (instr)
            SAMPLE_INSTR: sel = SEL_BSR;
            EXTEST_INSTR: begin
                sel = SEL_BSR;
                instr_mode = MODE_TEST;
            end
            IDCODE_INSTR: sel = SEL_WORD;
            USERCODE_INSTR: sel = SEL_WORD;
            HIGHZ_INSTR: instr_mode = MODE_HIGHZ;
            CLAMP_INSTR: instr_mode = MODE_CLAMP;
            USER_CHAIN_A_INSTR: sel = SEL_USER_A;
            USER_CHAIN_B_INSTR: sel = SEL_USER_B;
            default: sel = SEL_BYPASS;
        endcase
    end

    always_comb begin
        next_ir_shift = ir_shift;
        next_instr = instr;
        next_bypass = bypass;
        next_word = word;
        next_bsr = bsr;
        next_bsr_upd = bsr_upd;
        next_mode = instr_mode;
        next_upd_tgl = upd_tgl;
        case (state)
            CAP_IR: next_ir_shift = IR_CAPTURE_VAL;
            SHIFT_IR: next_ir_shift = {tdi, ir_shift[IR_LEN-1:1]};
            CAP_DR: begin
                next_bypass = 1'b0;
                if (instr == USERCODE_INSTR) begin
                    next_word = USERCODE_VAL;
                end else begin
                    next_word = IDCODE_VAL | IDCODE_LSB_MASK;
                end
                for (int i = 0; i < NPINS; i++) begin
                    next_bsr[i*CELL_W+CELL_IN] = pin_sync[i];
                end
            end
            SHIFT_DR: begin
                next_bypass = tdi;
                next_word = {tdi, word[DR_LEN-1:1]};
                if (sel == SEL_BSR) begin
                    next_bsr = {tdi, bsr[BSR_LEN-1:1]};
                end
            end
            UPD_DR: begin
                if (sel == SEL_BSR) begin
                    next_bsr_upd = bsr;
                    next_upd_tgl = ~upd_tgl;
                end
            end
            UPD_IR: next_upd_tgl = ~upd_tgl;
            default: next_bypass = bypass;
        endcase
        if (next_state == UPD_IR) begin
            next_instr = ir_shift;
        end
        if (state == TLR) begin
            next_instr = IDCODE_INSTR;
        end
        next_a_sel = (sel == SEL_USER_A);
        next_b_sel = (sel == SEL_USER_B);
        next_ucap = (next_state == CAP_DR) && (next_a_sel || next_b_sel);
        next_ushift = (next_state == SHIFT_DR) && (next_a_sel || next_b_sel);
        next_uupd = (next_state == UPD_DR) && (next_a_sel || next_b_sel);
    end

    always_ff @(posedge tck) begin
        if (tap_reset) begin
            ir_shift <= IR_CAPTURE_VAL;
            instr <= IDCODE_INSTR;
            bypass <= 1'b0;
            word <= '0;
            bsr <= '0;
            bsr_upd <= '0;
            mode <= MODE_NORMAL;
            upd_tgl <= 1'b0;
            user_chain_a_sel <= 1'b0;
            user_chain_b_sel <= 1'b0;
            user_capture <= 1'b0;
            user_shift <= 1'b0;
            user_update <= 1'b0;
        end else begin
            ir_shift <= next_ir_shift;
            instr <= next_instr;
            bypass <= next_bypass;
            word <= next_word;
            bsr <= next_bsr;
            bsr_upd <= next_bsr_upd;
            mode <= next_mode;
            upd_tgl <= next_upd_tgl;
            user_chain_a_sel <= next_a_sel;
            user_chain_b_sel <= next_b_sel;
            user_capture <= next_ucap;
            user_shift <= next_ushift;
            user_update <= next_uupd;
        end
    end

    // Serial out changes on the falling edge so the tester samples a settled bit.
    always_comb begin
        next_tdo = bypass;
        next_tdo_oe = (state == SHIFT_DR) || (state == SHIFT_IR);
        if (state == SHIFT_IR) begin
            next_tdo = ir_shift[0];
        end else begin
            case (sel)
                SEL_WORD: next_tdo = word[0];
                SEL_BSR: next_tdo = bsr[0];
                SEL_USER_A: next_tdo = user_chain_a_tdo;
                SEL_USER_B: next_tdo = user_chain_b_tdo;
                default: next_tdo = bypass;
            endcase
        end
    end

    always_ff @(negedge tck) begin
        if (tap_reset) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo <= next_tdo;
            tdo_oe <= next_tdo_oe;
        end
    end

    // ****************************************************************
    // System clock domain
    // ****************************************************************
    // Mode and update cells are only taken after the toggle has crossed, by which
    // time they have been stable for several system clocks.
    logic tgl_sync;
    logic tgl_seen, next_tgl_seen;
    logic io_ok;
    logic [1:0] m_mode, next_m_mode;
    logic [BSR_LEN-1:0] m_upd, next_m_upd;
    logic [NPINS-1:0] next_pin_out, next_pin_oe;

    level_sync u_tgl_sync (
        .clk(mclk),
        .reset(rst),
        .d(upd_tgl),
        .q(tgl_sync)
    );
    level_sync u_io_sync (
        .clk(mclk),
        .reset(rst),
        .d(io_bank_supply),
        .q(io_ok)
    );

    always_comb begin
        next_tgl_seen = tgl_sync;
        next_m_mode = m_mode;
        next_m_upd = m_upd;
        if (tgl_sync != tgl_seen) begin
            next_m_mode = mode;
            next_m_upd = bsr_upd;
        end
        for (int i = 0; i < NPINS; i++) begin
            case (m_mode)
                MODE_TEST, MODE_CLAMP: begin
                    next_pin_out[i] = m_upd[i*CELL_W+CELL_OUT];
                    next_pin_oe[i] = m_upd[i*CELL_W+CELL_OE] & io_ok;
                end
                MODE_HIGHZ: begin
                    next_pin_out[i] = 1'b0;
                    next_pin_oe[i] = 1'b0;
                end
                default: begin
                    next_pin_out[i] = core_out[i];
                    next_pin_oe[i] = core_oe[i] & io_ok;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tgl_seen <= 1'b0;
            m_mode <= MODE_NORMAL;
            m_upd <= '0;
            pin_out <= '0;
            pin_oe <= '0;
            pin_keeper_en <= 1'b0;
            normal_op <= 1'b0;
        end else begin
            tgl_seen <= next_tgl_seen;
            m_mode <= next_m_mode;
            m_upd <= next_m_upd;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            pin_keeper_en <= 1'b1;
            normal_op <= io_ok;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_bypass_one_bit: assert property (@(posedge tck) disable iff (tap_reset)
        state == SHIFT_DR && sel == SEL_BYPASS |=> bypass == $past(tdi))
        else $error("bypass did not hold last serial bit");
    a_idcode_lsb_set: assert property (@(posedge tck) disable iff (tap_reset)
        state == CAP_DR && instr == IDCODE_INSTR |=> word[0] == 1'b1)
        else $error("identification word lowest bit not set");
    a_usercode_ones: assert property (@(posedge tck) disable iff (tap_reset)
        state == CAP_DR && instr == USERCODE_INSTR |=> word == USERCODE_VAL)
        else $error("user code word wrong after capture");
    a_instr_on_update: assert property (@(posedge tck) disable iff (tap_reset)
        state == EXIT1_IR && tms && next_state == UPD_IR |=> instr == $past(ir_shift))
        else $error("instruction not applied entering update");
    a_unknown_bypass: assert property (@(posedge tck) disable iff (tap_reset)
        instr == 10'h20C |-> sel == SEL_BYPASS)
        else $error("unlisted code did not select bypass");
    a_highz_pins_off: assert property (@(posedge mclk) disable iff (rst)
        m_mode == MODE_HIGHZ |=> pin_oe == '0)
        else $error("pins driven in high-impedance mode");
    a_keeper_held: assert property (@(posedge mclk) disable iff (rst)
        m_mode != MODE_NORMAL |=> pin_keeper_en)
        else $error("keeper dropped in test mode");
    a_clamp_pattern: assert property (@(posedge mclk) disable iff (rst)
        m_mode == MODE_CLAMP && io_ok |=> pin_oe[0] == $past(m_upd[CELL_OE]))
        else $error("clamp did not hold scan pattern");
    a_user_a_path: assert property (@(posedge tck) disable iff (tap_reset)
        state == SHIFT_DR && instr == USER_CHAIN_A_INSTR |-> next_tdo == user_chain_a_tdo)
        else $error("user chain a not on serial path");

    c_extest_mode: cover property (@(posedge mclk) disable iff (rst) m_mode == MODE_TEST);
    c_user_shift: cover property (@(posedge tck) disable iff (tap_reset) user_shift);
    c_sample_update: cover property (@(posedge tck) disable iff (tap_reset)
        state == UPD_DR && instr == SAMPLE_INSTR);

endmodule : jtag_boundary_scan_tap

//--- hdl/tap_pkg.sv
// Shared constants, instruction codes and state encodings of the boundary-scan port.
package tap_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NPINS = 4;
    localparam int IR_LEN = 10;
    localparam int DR_LEN = 32;
    localparam int CELL_W = 3;
    localparam int BSR_LEN = CELL_W * NPINS;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

    // ****************************************************************
    // Instruction codes
    // ****************************************************************
    localparam logic [IR_LEN-1:0] SAMPLE_INSTR = 10'h005;
    localparam logic [IR_LEN-1:0] IDCODE_INSTR = 10'h006;
    localparam logic [IR_LEN-1:0] USERCODE_INSTR = 10'h007;
    localparam logic [IR_LEN-1:0] CLAMP_INSTR = 10'h00A;
    localparam logic [IR_LEN-1:0] HIGHZ_INSTR = 10'h00B;
    localparam logic [IR_LEN-1:0] USER_CHAIN_A_INSTR = 10'h00C;
    localparam logic [IR_LEN-1:0] USER_CHAIN_B_INSTR = 10'h00E;
    localparam logic [IR_LEN-1:0] EXTEST_INSTR = 10'h00F;
    localparam logic [IR_LEN-1:0] BYPASS_INSTR = 10'h3FF;
    localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 10'h001;

    // ****************************************************************
    // Data register values
    // ****************************************************************
    localparam logic [DR_LEN-1:0] USERCODE_DEFAULT = 32'hFFFFFFFF;
    localparam logic [DR_LEN-1:0] IDCODE_DEFAULT = 32'h0F0F0F0F; // Arbitrary value.
    localparam logic [DR_LEN-1:0] IDCODE_LSB_MASK = 32'h00000001;

    // ****************************************************************
    // Serial path selection and pin modes
    // ****************************************************************
    localparam logic [2:0] SEL_BYPASS = 3'h0;
    localparam logic [2:0] SEL_WORD = 3'h1;
    localparam logic [2:0] SEL_BSR = 3'h2;
    localparam logic [2:0] SEL_USER_A = 3'h3;
    localparam logic [2:0] SEL_USER_B = 3'h4;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_TEST = 2'h1;
    localparam logic [1:0] MODE_CLAMP = 2'h2;
    localparam logic [1:0] MODE_HIGHZ = 2'h3;

    // ****************************************************************
    // Test-port controller states
    // ****************************************************************
    typedef enum logic [15:0] {
        TLR = 16'h0001,
        RTI = 16'h0002,
        SEL_DR = 16'h0004,
        CAP_DR = 16'h0008,
        SHIFT_DR = 16'h0010,
        EXIT1_DR = 16'h0020,
        PAUSE_DR = 16'h0040,
        EXIT2_DR = 16'h0080,
        UPD_DR = 16'h0100,
        SEL_IR = 16'h0200,
        CAP_IR = 16'h0400,
        SHIFT_IR = 16'h0800,
        EXIT1_IR = 16'h1000,
        PAUSE_IR = 16'h2000,
        EXIT2_IR = 16'h4000,
        UPD_IR = 16'h8000
    } tap_state_e;

endpackage : tap_pkg

//--- hdl/level_sync.sv
// Three-stage level synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module level_sync
    import tap_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Level
    input wire logic d,
    output logic q
);

    logic s1;
    logic s2;
    logic s3;
    logic next_q;

    always_comb begin
        next_q = q;
        if (s2 == s3) begin
            next_q = s3;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end

endmodule : level_sync

//--- hdl/tap_fsm.sv
// Sixteen-state test-port controller.
`timescale 1ns/1ps
module tap_fsm
    import tap_pkg::*;
(
    // Clock and reset
    input wire logic tck,
    input wire logic reset,
    // Mode select
    input wire logic tms,
    // State
    output tap_state_e state,
    output tap_state_e next_state
);

    always_comb begin
        case (state)
            TLR: next_state = tms ? TLR : RTI;
            RTI: next_state = tms ? SEL_DR : RTI;
            SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
            CAP_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_state = tms ? UPD_DR : PAUSE_DR;
            PAUSE_DR: next_state = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_state = tms ? UPD_DR : SHIFT_DR;
            UPD_DR: next_state = tms ? SEL_DR : RTI;
            SEL_IR: next_state = tms ? TLR : CAP_IR;
            CAP_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_state = tms ? UPD_IR : PAUSE_IR;
            PAUSE_IR: next_state = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_state = tms ? UPD_IR : SHIFT_IR;
            UPD_IR: next_state = tms ? SEL_DR : RTI;
            default: next_state = TLR;
        endcase
    end

    always_ff @(posedge tck) begin
        if (reset) begin
            state <= TLR;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_five_tms_reset: assert property (@(posedge tck) disable iff (reset)
        tms [*5] |=> state == TLR)
        else $error("five high mode-select edges did not reach reset state");
    a_ir_path_order: assert property (@(posedge tck) disable iff (reset)
        state == SEL_IR && !tms ##1 !tms |=> state == SHIFT_IR)
        else $error("instruction path did not reach shift");

    c_ir_update: cover property (@(posedge tck) disable iff (reset) state == UPD_IR);
    c_dr_pause: cover property (@(posedge tck) disable iff (reset)
        state == PAUSE_DR ##1 state == EXIT2_DR ##1 state == SHIFT_DR);

endmodule : tap_fsm

//--- verification/tap_tester.sv
// Behavioural tester that clocks test-port frames and reads back serial data.
`timescale 1ns/1ps
module tap_tester (
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    logic q;

    // ********
    // Frames
    // ********
    initial begin
        tck = 1'b0; // Clock rests low between frames so no stray edge occurs.
        tms = 1'b1;
        tdi = 1'b0;
    end

    task automatic pulse(input logic m, input logic d);
        #1 q = tdo;
        tms = m;
        tdi = d;
        #2 tck = 1'b1;
        #3 tck = 1'b0;
    endtask : pulse

    // Outside shifting the data line toggles, so no stale level can pass for real data.
    task automatic walk(input logic [7:0] ms, input int n);
        for (int i = 0; i < n; i++) begin
            pulse(ms[i], ~tdi);
        end
    endtask : walk

    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        dout = '0;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i]);
            dout[i] = q;
        end
        walk(8'h01, 2);
    endtask : scan
endmodule : tap_tester

//--- verification/jtag_boundary_scan_tap_bench.sv
// Self-checking bench for the boundary-scan test port driven by a tester model.
`timescale 1ns/1ps
`define CHECK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module jtag_boundary_scan_tap_bench
    import tap_pkg::*;
;
    localparam logic [DR_LEN-1:0] ID_VAL = 32'h12345678; // Arbitrary value.
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic core_supply = 1'b0;
    logic io_bank_supply = 1'b0;
    logic [NPINS-1:0] core_out = 4'h3;
    logic [NPINS-1:0] core_oe = 4'hC;
    logic [NPINS-1:0] pin_in = 4'h5;
    logic tck, tms, tdi, tdo, tdo_oe, normal_op, pin_keeper_en;
    logic user_chain_a_sel, user_chain_b_sel, user_capture, user_shift, user_update;
    logic [NPINS-1:0] pin_out, pin_oe;
    logic [31:0] got;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int n_oe = 0;
    int n_ucap = 0;
    int n_ush = 0;
    int n_uupd = 0;

    always #25 mclk = ~mclk;

    tap_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    jtag_boundary_scan_tap #(.IDCODE_VAL(ID_VAL)) dut (
        .mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .core_supply(core_supply), .io_bank_supply(io_bank_supply), .normal_op(normal_op),
        .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_keeper_en(pin_keeper_en), .user_chain_a_tdo(1'b1),
        .user_chain_b_tdo(1'b0), .user_chain_a_sel(user_chain_a_sel),
        .user_chain_b_sel(user_chain_b_sel), .user_capture(user_capture),
        .user_shift(user_shift), .user_update(user_update));

    // ********
    // Helpers
    // ********
    function automatic logic [11:0] mk(input logic [3:0] o, input logic [3:0] e);
        logic [11:0] v;
        v = '0;
        for (int i = 0; i < 4; i++) begin
            v[3*i+1] = o[i];
            v[3*i+2] = e[i];
        end
        return v;
    endfunction : mk

    function automatic logic [3:0] cap(input logic [31:0] v);
        return {v[9], v[6], v[3], v[0]};
    endfunction : cap

    // The pause lets each pin update cross into the system clock before the next one.
    task automatic load(input logic [9:0] code);
        tst.scan(1'b1, 10, {22'h0, code}, got);
        repeat (12) @(posedge mclk);
    endtask : load

    task automatic dr(input int n, input logic [31:0] din);
        n_oe = 0;
        tst.scan(1'b0, n, din, got);
        `CHECK(n_oe, n)
        repeat (12) @(posedge mclk);
    endtask : dr

    // Strobes are counted on the edge opposite to the one that launches them.
    always @(posedge tck) begin
        n_oe <= n_oe + int'(tdo_oe);
    end

    always @(negedge tck) begin
        n_ucap <= n_ucap + int'(user_capture);
        n_ush <= n_ush + int'(user_shift);
        n_uupd <= n_uupd + int'(user_update);
    end

    task automatic end_of_test();
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // ********
    // Scenarios
    // ********
    task automatic power_up();
        tst.walk(8'hFF, 4);
        @(posedge mclk) core_supply <= 1'b1;
        tst.walk(8'hFF, 8);
        tst.pulse(1'b0, 1'b0);
        dr(32, 32'h0);
        `CHECK(got, 32'h12345679)
    endtask : power_up

    task automatic usercode_read();
        load(USERCODE_INSTR);
        `CHECK(got[9:0], IR_CAPTURE_VAL)
        dr(32, 32'h0);
        `CHECK(got, USERCODE_DEFAULT)
    endtask : usercode_read

    task automatic bypass_paths();
        load(BYPASS_INSTR);
        dr(8, 32'hB5);
        `CHECK(got[7:0], 8'h6A)
        load(10'h20C);
        dr(8, 32'hB5);
        `CHECK(got[7:0], 8'h6A)
    endtask : bypass_paths

    task automatic user_chains();
        for (int j = 0; j < 2; j++) begin
            load(j ? USER_CHAIN_B_INSTR : USER_CHAIN_A_INSTR);
            `CHECK({user_chain_b_sel, user_chain_a_sel}, j ? 2'b10 : 2'b01)
            n_ucap = 0;
            n_ush = 0;
            n_uupd = 0;
            dr(8, j ? 32'hFF : 32'h0);
            `CHECK(got[7:0], j ? 8'h00 : 8'hFF)
            `CHECK({n_ucap[3:0], n_ush[3:0], n_uupd[3:0]}, 12'h181)
        end
    endtask : user_chains

    task automatic pin_modes();
        @(posedge mclk) io_bank_supply <= 1'b1; // Banks are up before pin testing.
        load(SAMPLE_INSTR);
        dr(12, {20'h0, mk(4'hA, 4'h6)});
        `CHECK(cap(got), 4'h5)
        `CHECK({normal_op, pin_oe, pin_out}, 9'h1C3)
        @(posedge mclk) pin_in <= 4'h9;
        load(EXTEST_INSTR);
        `CHECK({pin_oe, pin_out}, 8'h6A)
        dr(12, {20'h0, mk(4'h5, 4'hF)});
        `CHECK(cap(got), 4'h9)
        `CHECK({pin_keeper_en, pin_oe, pin_out}, 9'h1F5)
        load(CLAMP_INSTR);
        dr(8, 32'hB5);
        `CHECK({got[7:0], pin_oe, pin_out}, 16'h6AF5)
        load(HIGHZ_INSTR);
        dr(8, 32'hB5);
        `CHECK({got[7:0], pin_keeper_en, pin_oe}, 13'h0D50)
    endtask : pin_modes

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        power_up();
        usercode_read();
        bypass_paths();
        user_chains();
        pin_modes();
        end_of_test();
    end
endmodule : jtag_boundary_scan_tap_bench
